// ---- hdl/cswd_tick_div.sv ----
// Divider that turns the clock into a one-cycle enable pulse every DIVIDE cycles in which enable_in is high.
// Assumes the clear input restarts the phase so the first pulse is a full period away.
`timescale 1ns/1ps
`default_nettype none
module cswd_tick_div
#(
  parameter int DIVIDE = 2
)
(
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  input  wire logic clear_in,
  input  wire logic enable_in,
  output logic      tick_out
);
  localparam int W = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [W-1:0] LAST = W'(DIVIDE - 1);
  logic [W-1:0] phase;

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      phase    <= '0;
      tick_out <= 1'b0;
    end
    else if (clear_in)
    begin
      phase    <= '0;
      tick_out <= 1'b0;
    end
    else if (enable_in)
    begin
      tick_out <= (phase == LAST);
      phase    <= (phase == LAST) ? '0 : phase + 1'b1;
    end
    else
    begin
      tick_out <= 1'b0;
    end
  end
endmodule : cswd_tick_div
`default_nettype wire

// ---- hdl/cswd_watchdog.sv ----
// Countdown supervision timer reached through an index/data configuration port pair.
// Assumes host I/O cycles arrive as one-cycle strobes synchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
module cswd_watchdog
  import cswd_pkg::*;
#(
  parameter int SECOND_CYCLES = CSWD_SECOND_CYCLES,
  parameter int MINUTE_TICKS  = CSWD_SEC_PER_MINUTE,
  parameter int RESET_CYCLES  = CSWD_RESET_CYCLES
)
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       io_write_in,
  input  wire logic       io_read_in,
  input  wire logic [7:0] io_addr_in,
  input  wire logic [7:0] io_wdata_in,
  output logic      [7:0] io_rdata_out,
  output logic            io_rvalid_out,
  output logic            active_out,
  output logic            sys_reset_out
);

  // ****************************************************************
  // Configuration port decode
  // ****************************************************************
  typedef enum logic [1:0] {CSWD_LOCKED, CSWD_HALF, CSWD_OPEN} cswd_lock_t;
  cswd_lock_t lock_state;
  logic [7:0] index;
  logic [7:0] ldn;
  logic [7:0] watchdog_activate;
  logic [7:0] watchdog_time_unit;
  logic [7:0] watchdog_timeout_count;
  logic [7:0] remaining;
  logic       fired;

  wire logic wr_index = io_write_in && (io_addr_in == CSWD_PORT_INDEX);
  wire logic wr_data  = io_write_in && (io_addr_in == CSWD_PORT_DATA) && (lock_state == CSWD_OPEN);
  wire logic rd_data  = io_read_in && (io_addr_in == CSWD_PORT_DATA) && (lock_state == CSWD_OPEN);
  wire logic in_ldn   = (ldn == CSWD_LDN_TIMER);
  wire logic wr_act   = wr_data && in_ldn && (index == CSWD_IDX_ACTIVATE);
  wire logic wr_unit  = wr_data && in_ldn && (index == CSWD_IDX_UNIT);
  wire logic wr_count = wr_data && in_ldn && (index == CSWD_IDX_COUNT);
  wire logic running  = watchdog_activate[0];

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      lock_state <= CSWD_LOCKED;
    else if (wr_index)
    begin
      case (lock_state)
        CSWD_LOCKED: lock_state <= (io_wdata_in == CSWD_UNLOCK_KEY) ? CSWD_HALF : CSWD_LOCKED;
        CSWD_HALF:   lock_state <= (io_wdata_in == CSWD_UNLOCK_KEY) ? CSWD_OPEN : CSWD_LOCKED;
        CSWD_OPEN:   lock_state <= (io_wdata_in == CSWD_LOCK_KEY) ? CSWD_LOCKED : CSWD_OPEN;
        default:     lock_state <= CSWD_LOCKED;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      index <= CSWD_RST_REG;
    else if (wr_index && lock_state == CSWD_OPEN)
      index <= io_wdata_in;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      ldn <= CSWD_RST_REG;
    else if (wr_data && index == CSWD_IDX_LDN)
      ldn <= io_wdata_in;
  end

  // ****************************************************************
  // Watchdog registers
  // ****************************************************************
  // The activation register stores the whole byte but only bit 0 arms the timer.
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      watchdog_activate <= CSWD_RST_REG;
    else if (wr_act)
      watchdog_activate <= io_wdata_in;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      watchdog_time_unit <= CSWD_RST_REG;
    else if (wr_unit)
      watchdog_time_unit <= io_wdata_in;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      watchdog_timeout_count <= CSWD_RST_REG;
    else if (wr_count)
      watchdog_timeout_count <= io_wdata_in;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      io_rdata_out  <= 8'h00;
      io_rvalid_out <= 1'b0;
    end
    else
    begin
      io_rvalid_out <= io_read_in;
      if (io_read_in && io_addr_in == CSWD_PORT_INDEX)
        io_rdata_out <= index;
      else if (rd_data && index == CSWD_IDX_LDN)
        io_rdata_out <= ldn;
      else if (rd_data && in_ldn && index == CSWD_IDX_ACTIVATE)
        io_rdata_out <= watchdog_activate;
      else if (rd_data && in_ldn && index == CSWD_IDX_UNIT)
        io_rdata_out <= watchdog_time_unit;
      else if (rd_data && in_ldn && index == CSWD_IDX_COUNT)
        io_rdata_out <= remaining;
      else
        io_rdata_out <= 8'hff;
    end
  end

  // ****************************************************************
  // Time base
  // ****************************************************************
  // Any arming, disarming or reload restarts both dividers, so the first unit is whole.
  logic sec_tick;
  logic unit_tick;
  logic min_tick;
  wire logic restart = wr_act || wr_count || !running;
  wire logic minute_mode = watchdog_time_unit[CSWD_UNIT_BIT];

  cswd_tick_div #(.DIVIDE(SECOND_CYCLES)) u_second
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .clear_in   (restart),
    .enable_in  (1'b1),
    .tick_out   (sec_tick)
  );

  cswd_tick_div #(.DIVIDE(MINUTE_TICKS)) u_minute
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .clear_in   (restart),
    .enable_in  (sec_tick),
    .tick_out   (min_tick)
  );

  assign unit_tick = minute_mode ? min_tick : sec_tick;

  // ****************************************************************
  // Countdown and reset
  // ****************************************************************
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      remaining <= 8'h00;
    else if (wr_count)
      remaining <= io_wdata_in;
    else if (wr_act && io_wdata_in[0])
      remaining <= watchdog_timeout_count;
    else if (running && unit_tick && remaining != 8'h00 && !fired)
      remaining <= remaining - 8'h01;
  end

  // Expiry is latched; a zero loaded by software never counts as expiry.
  // A count rewrite or re-arm clears the latch so that a reload counts down again.
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      fired <= 1'b0;
    else if (running && unit_tick && remaining == 8'h01 && !wr_count && !wr_act)
      fired <= 1'b1;
    else if (wr_count || wr_act || !running)
      fired <= 1'b0;
  end

  logic [15:0] pulse_cnt;
  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pulse_cnt     <= 16'h0000;
      sys_reset_out <= 1'b0;
    end
    else if (running && unit_tick && remaining == 8'h01 && !wr_count && !wr_act && !fired)
    begin
      pulse_cnt     <= 16'(RESET_CYCLES - 1);
      sys_reset_out <= 1'b1;
    end
    else if (pulse_cnt != 16'h0000)
      pulse_cnt <= pulse_cnt - 16'h0001;
    else
      sys_reset_out <= 1'b0;
  end

  assign active_out = running;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_last_unit;
    running && unit_tick && remaining == 8'h01 && !wr_count && !wr_act && !fired;
  endsequence

  a_expiry_resets: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    s_last_unit |=> sys_reset_out && remaining == 8'h00)
    else $error("expiry did not raise reset");
  a_zero_no_reset: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $rose(sys_reset_out) |-> $past(remaining) == 8'h01)
    else $error("reset without count reaching zero");
  a_decrement_one: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (running && unit_tick && remaining > 8'h01 && !wr_count && !wr_act)
      |=> remaining == $past(remaining) - 8'h01)
    else $error("count did not step by one");
  a_idle_hold: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!unit_tick && !wr_count && !wr_act) |=> remaining == $past(remaining))
    else $error("count moved without a unit tick");
  a_disable_any: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (wr_act && io_wdata_in == 8'h00) |=> !active_out)
    else $error("disable write ignored");
  a_reload_count: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wr_count |=> remaining == $past(io_wdata_in) && watchdog_timeout_count == $past(io_wdata_in))
    else $error("count write did not reload");
  a_unit_minute: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ($changed(remaining) && !$past(wr_count) && !$past(wr_act) && $past(minute_mode))
      |-> $past(min_tick))
    else $error("minute mode stepped without a minute tick");
  a_unit_second: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ($changed(remaining) && !$past(wr_count) && !$past(wr_act) && !$past(minute_mode))
      |-> $past(sec_tick))
    else $error("second mode stepped without a second tick");
  a_unlock_seq: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (lock_state == CSWD_LOCKED && wr_index) |=> lock_state != CSWD_OPEN)
    else $error("opened after one key");
  a_unit_store: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    wr_unit |=> watchdog_time_unit == $past(io_wdata_in))
    else $error("unit register not written");

endmodule : cswd_watchdog
`default_nettype wire

// ---- inc/cswd_pkg.sv ----
// Constants for the countdown supervision timer behind the index/data port pair.
// Assumes a single 125 MHz reference clock shared by every user of the package.
package cswd_pkg;

  // ****************************************************************
  // Port decode and configuration indices
  // ****************************************************************
  localparam logic [7:0] CSWD_PORT_INDEX   = 8'h2e;
  localparam logic [7:0] CSWD_PORT_DATA    = 8'h2f;
  localparam logic [7:0] CSWD_UNLOCK_KEY   = 8'h87;
  localparam logic [7:0] CSWD_LOCK_KEY     = 8'haa;
  localparam logic [7:0] CSWD_IDX_LDN      = 8'h07;
  localparam logic [7:0] CSWD_LDN_TIMER    = 8'h07;
  localparam logic [7:0] CSWD_IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] CSWD_IDX_UNIT     = 8'hf5;
  localparam logic [7:0] CSWD_IDX_COUNT    = 8'hf6;

  // ****************************************************************
  // Field values and reset values
  // ****************************************************************
  localparam logic [7:0] CSWD_ACT_ON       = 8'h01;
  localparam logic [7:0] CSWD_UNIT_SECOND  = 8'h00;
  localparam logic [7:0] CSWD_UNIT_MINUTE  = 8'h08;
  localparam int         CSWD_UNIT_BIT     = 3;
  localparam logic [7:0] CSWD_RST_REG      = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CSWD_CLK_HZ          = 125000000;
  localparam int CSWD_SECOND_S        = 1;
  localparam int CSWD_SECOND_CYCLES   = CSWD_CLK_HZ * CSWD_SECOND_S;
  localparam int CSWD_SEC_PER_MINUTE  = 60;
  localparam int CSWD_RESET_PULSE_NS  = 1000;
  localparam int CSWD_RESET_CYCLES    = (CSWD_RESET_PULSE_NS * (CSWD_CLK_HZ / 1000000)
                                         + 999) / 1000;

endpackage : cswd_pkg

// ---- testbench/cswd_watchdog_tb.sv ----
// Self-checking testbench for the countdown supervision timer.
// Assumes the design takes one-cycle host strobes and answers reads one cycle later.
`timescale 1ns/1ps
`default_nettype none
module cswd_watchdog_tb;
  import cswd_pkg::*;

  // ****************************************************************
  // Shortened time base so that minute counts finish quickly
  // ****************************************************************
  localparam int SEC = 10;
  localparam int MIN = 3;
  localparam int RST = 4;

  logic       ref_clk_in;
  logic       reset_in;
  logic       io_write_in;
  logic       io_read_in;
  logic [7:0] io_addr_in;
  logic [7:0] io_wdata_in;
  logic [7:0] io_rdata_out;
  logic       io_rvalid_out;
  logic       active_out;
  logic       sys_reset_out;
  int         bad_count;
  int         n_compared;
  int         cyc;

  cswd_watchdog #(
    .SECOND_CYCLES (SEC),
    .MINUTE_TICKS  (MIN),
    .RESET_CYCLES  (RST)
  ) cswd_watchdog_i (
    .ref_clk_in    (ref_clk_in),
    .reset_in      (reset_in),
    .io_write_in   (io_write_in),
    .io_read_in    (io_read_in),
    .io_addr_in    (io_addr_in),
    .io_wdata_in   (io_wdata_in),
    .io_rdata_out  (io_rdata_out),
    .io_rvalid_out (io_rvalid_out),
    .active_out    (active_out),
    .sys_reset_out (sys_reset_out)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // ****************************************************************
  // Checking and reporting
  // ****************************************************************
  task automatic end_sim();
    $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // A hung wait would otherwise run forever, so the whole run is capped.
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      $display("ERROR at %0t: run did not finish in time", $time);
      end_sim();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  // ****************************************************************
  // Host port access
  // ****************************************************************
  task automatic port_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    io_write_in <= 1'b1;
    io_addr_in  <= a;
    io_wdata_in <= d;
    @(posedge ref_clk_in);
    io_write_in <= 1'b0;
    #1;
  endtask : port_wr

  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] val);
    port_wr(CSWD_PORT_INDEX, idx);
    port_wr(CSWD_PORT_DATA, val);
  endtask : cfg_wr

  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
    port_wr(CSWD_PORT_INDEX, idx);
    @(posedge ref_clk_in);
    io_read_in <= 1'b1;
    io_addr_in <= CSWD_PORT_DATA;
    @(posedge ref_clk_in);
    io_read_in <= 1'b0;
    #1;
    chk1(io_rvalid_out, 1'b1, "read answer");
    chk8(io_rdata_out, exp, what);
  endtask : cfg_rd

  // Expiry is allowed a few cycles of slack for the strobe pipeline.
  task automatic expect_expiry(input int t);
    int k;
    int w;
    k = 0;
    w = 0;
    while (sys_reset_out !== 1'b1 && k < t + 10)
    begin
      @(posedge ref_clk_in);
      #1;
      k++;
    end
    chk1(k >= t - 3 && k <= t + 3, 1'b1, "expiry moment");
    while (sys_reset_out === 1'b1 && w < RST + 5)
    begin
      @(posedge ref_clk_in);
      #1;
      w++;
    end
    chk8(w[7:0], RST[7:0], "reset pulse length");
  endtask : expect_expiry

  task automatic quiet(input int t);
    repeat (t)
    begin
      @(posedge ref_clk_in);
      #1;
      chk1(sys_reset_out, 1'b0, "no reset expected");
    end
  endtask : quiet

  task automatic arm(input logic [7:0] unit, input logic [7:0] count);
    cfg_wr(CSWD_IDX_ACTIVATE, 8'h00);
    cfg_wr(CSWD_IDX_UNIT, unit);
    cfg_wr(CSWD_IDX_COUNT, count);
    cfg_wr(CSWD_IDX_ACTIVATE, CSWD_ACT_ON);
  endtask : arm

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    reset_in    = 1'b1;
    io_write_in = 1'b0;
    io_read_in  = 1'b0;
    io_addr_in  = 8'h00;
    io_wdata_in = 8'h00;
    bad_count   = 0;
    n_compared  = 0;
    cyc         = 0;
    repeat (20) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    cfg_wr(CSWD_IDX_ACTIVATE, CSWD_ACT_ON);
    chk1(active_out, 1'b0, "locked activation ignored");
    cfg_rd(CSWD_IDX_ACTIVATE, 8'hff, "locked data read");
    port_wr(CSWD_PORT_INDEX, CSWD_UNLOCK_KEY);
    port_wr(CSWD_PORT_INDEX, CSWD_UNLOCK_KEY);
    cfg_rd(CSWD_IDX_UNIT, 8'hff, "other device read");
    cfg_wr(CSWD_IDX_LDN, CSWD_LDN_TIMER);
    cfg_rd(CSWD_IDX_UNIT, 8'h00, "unit after reset");
    cfg_rd(CSWD_IDX_COUNT, 8'h00, "count after reset");
    cfg_rd(8'h55, 8'hff, "unmapped index");
    cfg_wr(CSWD_IDX_COUNT, 8'hff);
    cfg_rd(CSWD_IDX_COUNT, 8'hff, "full count stored");
    $display("Test registers done");
    arm(CSWD_UNIT_SECOND, 8'h04);
    chk1(active_out, 1'b1, "activated");
    repeat (SEC + 3) @(posedge ref_clk_in);
    cfg_rd(CSWD_IDX_COUNT, 8'h03, "one decrement");
    cfg_wr(CSWD_IDX_ACTIVATE, 8'h00);
    chk1(active_out, 1'b0, "disabled mid count");
    quiet(6 * SEC);
    $display("Test decrement and disable done");
    arm(CSWD_UNIT_SECOND, 8'h03);
    expect_expiry(3 * SEC);
    $display("Test second expiry done");
    arm(CSWD_UNIT_MINUTE, 8'h02);
    expect_expiry(2 * SEC * MIN);
    $display("Test minute expiry done");
    arm(CSWD_UNIT_SECOND, 8'h03);
    repeat (2 * SEC) @(posedge ref_clk_in);
    cfg_wr(CSWD_IDX_COUNT, 8'h03);
    expect_expiry(3 * SEC);
    $display("Test restart done");
    arm(CSWD_UNIT_SECOND, 8'h00);
    quiet(5 * SEC);
    $display("Test zero count done");
    port_wr(CSWD_PORT_INDEX, CSWD_LOCK_KEY);
    cfg_rd(CSWD_IDX_COUNT, 8'hff, "relocked read");
    $display("Test relock done");
    end_sim();
  end

endmodule : cswd_watchdog_tb
`default_nettype wire
